// [hw/ued_dma_port.sv]
// ued_dma_port: microcontroller port and main endpoint dma request logic
`timescale 1ns/1ps
// What this block does
// - byte-wide port, one address bit, two locations
// - multiplexed and separate address/data buses work
// - address strobe never high: use address pin
// - address bit high command, low data
// - single mode: drop request at every acknowledge
// - burst mode: hold request for burst count
// - request until end notice, then flag done
// - reads: request only with complete packet buffered
// - short packet: drop at last byte, reload
// - writes: request while buffer not full
// - bulk writes send full buffers, end flushes
// - acknowledge routes access to main endpoint
// - dma interleaves with other endpoint accesses
// - stop on go clear or qualified end
// - single address: strobes without chip select
// - four endpoint modes supported
// - endpoints zero and one: sixteen-byte pairs
// - main endpoint sizes depend on mode
// - main endpoint double buffered, auto switching
module ued_dma_port
   import ued_pkg::*;
#(
   parameter int FIFO_DEPTH = UED_FIFO_DEPTH,
   parameter int BURST_W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // microcontroller bus
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic ale,
   input wire logic cmd_data_select,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   // dma handshake
   output logic dma_request_out,
   input wire logic dma_ack_n,
   input wire logic transfer_end_n,
   // configuration and status
   input wire logic dma_go,
   input wire logic burst_mode,
   input wire logic [BURST_W-1:0] burst_len,
   input wire logic dma_to_host,
   input ued_mode_t ep_mode,
   output logic dma_active,
   output logic dma_done,
   // command and other endpoints
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic ep_wr,
   output logic ep_rd,
   output logic [2:0] ep_index,
   output logic [7:0] ep_wdata,
   output logic [7:0] ep_max_size,
   input wire logic [7:0] ep_rdata,
   // usb engine
   input wire logic usb_rx_valid,
   input ued_byte_t usb_rx,
   output logic usb_rx_ready,
   input wire logic usb_in_token,
   output logic usb_tx_valid,
   output ued_byte_t usb_tx,
   input wire logic usb_tx_ready,
   input wire logic usb_tx_ack
);
   // ----------------------------------------------------------------
   // bus sampling and decode
   // ----------------------------------------------------------------
   logic rd_q_ff, wr_q_ff, mux_bus_ff, a0_ff;
   logic [7:0] wdata_ff;
   logic [2:0] sel_ep_ff;
   logic rd_fall, rd_rise, wr_rise, sel_cmd, cpu_sel, dma_sel, main_sel;
   logic main_wr, main_rd_done, other_sel;

   assign rd_fall = rd_q_ff & ~rd_n;
   assign rd_rise = ~rd_q_ff & rd_n;
   assign wr_rise = ~wr_q_ff & wr_n;
   assign sel_cmd = mux_bus_ff ? a0_ff : cmd_data_select;
   assign dma_sel = ~dma_ack_n;
   assign cpu_sel = ~cs_n & dma_ack_n;
   // ack wins over whatever endpoint software selected
   assign main_sel = dma_sel | (cpu_sel & ~sel_cmd & sel_ep_ff[2]);
   assign other_sel = cpu_sel & ~sel_cmd & ~sel_ep_ff[2];
   assign main_wr = wr_rise & main_sel;
   assign main_rd_done = rd_rise & main_sel;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_q_ff <= 1'b1;
         wr_q_ff <= 1'b1;
         mux_bus_ff <= 1'b0;
         a0_ff <= UED_A0_RST;
         wdata_ff <= 8'h00;
      end else begin
         rd_q_ff <= rd_n;
         wr_q_ff <= wr_n;
         if (~wr_n) wdata_ff <= data_in;
         // any address phase marks the bus as multiplexed
         if (ale) begin
            mux_bus_ff <= 1'b1;
            a0_ff <= data_in[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // commands and the other endpoints
   // ----------------------------------------------------------------
   logic cmd_valid_ff, ep_wr_ff, ep_rd_ff;
   logic [7:0] cmd_byte_ff, ep_wdata_ff, ep_max_size_ff, sel_size, out_size, in_size;

   ued_ep_map u_ep_map (
      .ep_mode(ep_mode),
      .sel_index(sel_ep_ff),
      .sel_size(sel_size),
      .main_out_size(out_size),
      .main_in_size(in_size)
   );

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cmd_valid_ff <= 1'b0;
         cmd_byte_ff <= 8'h00;
         sel_ep_ff <= UED_SEL_EP_RST;
         ep_wr_ff <= 1'b0;
         ep_rd_ff <= 1'b0;
         ep_wdata_ff <= 8'h00;
         ep_max_size_ff <= 8'h00;
      end else begin
         cmd_valid_ff <= wr_rise & cpu_sel & sel_cmd;
         ep_wr_ff <= wr_rise & other_sel;
         ep_rd_ff <= rd_fall & other_sel;
         ep_max_size_ff <= sel_size;
         if (wr_rise & cpu_sel) begin
            if (sel_cmd) cmd_byte_ff <= wdata_ff;
            else ep_wdata_ff <= wdata_ff;
            if (sel_cmd & (wdata_ff <= UED_SEL_CODE_LAST)) sel_ep_ff <= wdata_ff[2:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // double buffer of the main endpoint
   // ----------------------------------------------------------------
   logic [7:0] buf_mem_ff [2][UED_BUF_BYTES];
   logic [1:0] full_ff;
   logic [7:0] len_ff [2];
   logic fill_ff, drain_ff, eot_flush_ff, sending_ff, wait_ack_ff, pkt_end_ff;
   logic [6:0] wptr_ff, rptr_ff;
   logic rx_ready_ff, tx_valid_ff;
   ued_byte_t tx_ff;
   logic [7:0] pkt_size, wnext, rnext, wbyte;
   logic dir_ok, rx_take, f_take, wr_en, fill_end, flush_end, rd_take, pkt_end;
   logic f_in_valid, f_in_ready, f_out_valid;
   logic [7:0] f_out_data;

   assign pkt_size = dma_to_host ? in_size : out_size;
   assign dir_ok = (pkt_size != UED_SIZE_NONE);
   assign wnext = {1'b0, wptr_ff} + 8'h01;
   assign rnext = {1'b0, rptr_ff} + 8'h01;
   assign rx_take = ~dma_to_host & usb_rx_valid & rx_ready_ff;
   assign f_take = dma_to_host & f_out_valid & ~full_ff[fill_ff];
   assign wr_en = rx_take | f_take;
   assign wbyte = rx_take ? usb_rx.data : f_out_data;
   assign fill_end = wr_en & ((rx_take & usb_rx.last) | (wnext >= pkt_size));
   // end notice closes a partly filled buffer once the fifo is empty
   assign flush_end = eot_flush_ff & ~f_out_valid & ~full_ff[fill_ff] & (wptr_ff != 7'h00);
   assign rd_take = main_rd_done & ~dma_to_host & full_ff[drain_ff];
   assign pkt_end = rd_take & (rnext >= len_ff[drain_ff]);
   assign f_in_valid = dma_to_host & main_wr;

   ued_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(wdata_ff),
      .out_valid(f_out_valid),
      .out_ready(f_take),
      .out_data(f_out_data)
   );

   always_ff @(posedge ref_clk) begin
      if (wr_en) buf_mem_ff[fill_ff][wptr_ff] <= wbyte;
   end

   // fill side: usb packets for reads, fifo bytes for writes
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         full_ff <= 2'b00;
         len_ff[0] <= 8'h00;
         len_ff[1] <= 8'h00;
         fill_ff <= 1'b0;
         drain_ff <= 1'b0;
         wptr_ff <= 7'h00;
         rptr_ff <= 7'h00;
         rx_ready_ff <= 1'b0;
         pkt_end_ff <= 1'b0;
         sending_ff <= 1'b0;
         wait_ack_ff <= 1'b0;
         tx_valid_ff <= 1'b0;
         tx_ff <= '0;
      end else begin
         pkt_end_ff <= pkt_end;
         if (fill_end | flush_end) begin
            full_ff[fill_ff] <= 1'b1;
            len_ff[fill_ff] <= fill_end ? wnext : {1'b0, wptr_ff};
            fill_ff <= ~fill_ff;
            wptr_ff <= 7'h00;
         end else if (wr_en) begin
            wptr_ff <= wnext[6:0];
         end
         // ready looks ahead to the buffer that filling moves to
         rx_ready_ff <= ~dma_to_host & dir_ok
                        & (fill_end ? ~full_ff[~fill_ff] : ~full_ff[fill_ff]);
         // read drain over the microcontroller or dma strobes
         if (pkt_end) begin
            full_ff[drain_ff] <= 1'b0;
            drain_ff <= ~drain_ff;
            rptr_ff <= 7'h00;
         end else if (rd_take) begin
            rptr_ff <= rnext[6:0];
         end
         // write drain toward the host, repeated if no ack comes
         if (usb_in_token & dma_to_host & full_ff[drain_ff] & ~sending_ff) begin
            sending_ff <= 1'b1;
            wait_ack_ff <= 1'b0;
            rptr_ff <= 7'h00;
         end else if (sending_ff & (~tx_valid_ff | usb_tx_ready)) begin
            if (rnext <= len_ff[drain_ff]) begin
               tx_valid_ff <= 1'b1;
               tx_ff.data <= buf_mem_ff[drain_ff][rptr_ff];
               tx_ff.last <= (rnext == len_ff[drain_ff]);
               rptr_ff <= rnext[6:0];
            end else begin
               tx_valid_ff <= 1'b0;
               sending_ff <= 1'b0;
               wait_ack_ff <= 1'b1;
            end
         end
         if (wait_ack_ff & usb_tx_ack & ~sending_ff) begin
            full_ff[drain_ff] <= 1'b0;
            drain_ff <= ~drain_ff;
            wait_ack_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // read data onto the bus
   // ----------------------------------------------------------------
   logic [7:0] data_out_ff;
   logic data_oe_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         data_out_ff <= 8'h00;
         data_oe_ff <= 1'b0;
      end else begin
         if (rd_fall & (cpu_sel | dma_sel)) data_oe_ff <= 1'b1;
         else if (rd_n) data_oe_ff <= 1'b0;
         if (rd_fall & main_sel) begin
            data_out_ff <= full_ff[drain_ff] ? buf_mem_ff[drain_ff][rptr_ff] : 8'h00;
         end else if (ep_rd_ff) begin
            data_out_ff <= ep_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // dma sequencing and request
   // ----------------------------------------------------------------
   ued_state_t state_ff;
   logic req_ff, gap_ff, done_ff, active_ff;
   logic [BURST_W-1:0] cnt_ff, cnt_next;
   logic eot_hit, xfer_done, burst_end, can_req;

   assign eot_hit = ~transfer_end_n & ~dma_ack_n & (~rd_n | ~wr_n);
   assign xfer_done = (main_wr | main_rd_done) & ~dma_ack_n;
   assign cnt_next = cnt_ff + 1'b1;
   assign burst_end = xfer_done & (~burst_mode | (cnt_next >= burst_len));
   assign can_req = dir_ok & (dma_to_host
                    ? (~full_ff[fill_ff] & f_in_ready & ~eot_flush_ff)
                    : full_ff[drain_ff]);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= UED_ST_IDLE;
         done_ff <= 1'b0;
         active_ff <= 1'b0;
         eot_flush_ff <= 1'b0;
      end else begin
         done_ff <= (state_ff == UED_ST_RUN) & dma_go & eot_hit;
         active_ff <= (state_ff == UED_ST_RUN) & dma_go & ~eot_hit;
         if (eot_hit & dma_to_host & (state_ff == UED_ST_RUN)) eot_flush_ff <= 1'b1;
         else if (eot_flush_ff & ~f_out_valid & ~eot_hit) eot_flush_ff <= 1'b0;
         unique case (state_ff)
            UED_ST_IDLE: begin
               if (dma_go) state_ff <= UED_ST_RUN;
            end
            UED_ST_RUN: begin
               if (~dma_go) state_ff <= UED_ST_IDLE;
               else if (eot_hit) state_ff <= UED_ST_DONE;
            end
            UED_ST_DONE: begin
               if (~dma_go) state_ff <= UED_ST_IDLE;
            end
            default: state_ff <= UED_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         gap_ff <= 1'b0;
      end else if (pkt_end | burst_end) begin
         gap_ff <= 1'b1;
         cnt_ff <= '0;
      end else if (xfer_done) begin
         cnt_ff <= cnt_next;
      end else if (gap_ff & dma_ack_n) begin
         gap_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         req_ff <= 1'b0;
      end else begin
         // single mode lets go while ack is low so every cycle is re-requested
         req_ff <= (state_ff == UED_ST_RUN) & dma_go & can_req & ~gap_ff
                   & ~pkt_end & ~burst_end & ~eot_hit
                   & ~(~burst_mode & ~dma_ack_n);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign data_out = data_out_ff;
   assign data_oe = data_oe_ff;
   assign dma_request_out = req_ff;
   assign dma_active = active_ff;
   assign dma_done = done_ff;
   assign cmd_valid = cmd_valid_ff;
   assign cmd_byte = cmd_byte_ff;
   assign ep_wr = ep_wr_ff;
   assign ep_rd = ep_rd_ff;
   assign ep_index = sel_ep_ff;
   assign ep_wdata = ep_wdata_ff;
   assign ep_max_size = ep_max_size_ff;
   assign usb_rx_ready = rx_ready_ff;
   assign usb_tx_valid = tx_valid_ff;
   assign usb_tx = tx_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_req_go_off: assert property (!dma_go |=> !dma_request_out)
      else $error("request raised while go is clear");
   a_single_drop: assert property (!burst_mode && !dma_ack_n |=> !dma_request_out)
      else $error("single mode request held during acknowledge");
   a_burst_release: assert property (burst_end |=> !dma_request_out ##1 !dma_request_out)
      else $error("request not released after burst");
   a_eot_done: assert property (state_ff == UED_ST_RUN && dma_go && eot_hit |=>
      dma_done && state_ff == UED_ST_DONE ##1 !dma_done)
      else $error("end notice did not finish dma");
   a_read_complete: assert property (!dma_to_host && !full_ff[drain_ff] |=> !dma_request_out)
      else $error("read request without complete packet");
   a_short_packet: assert property (pkt_end |=> !dma_request_out && cnt_ff == '0)
      else $error("request or count kept past packet end");
   a_write_room: assert property (dma_to_host && full_ff[fill_ff] |=> !dma_request_out)
      else $error("write request with no buffer room");
   a_ack_routes: assert property (wr_rise && !dma_ack_n |=> !ep_wr && !cmd_valid)
      else $error("acknowledged access left the main endpoint");
   a_go_stop: assert property (state_ff == UED_ST_RUN && !dma_go |=> state_ff == UED_ST_IDLE)
      else $error("clearing go did not stop dma");
   a_eot_qualified: assert property (state_ff == UED_ST_RUN && dma_go && dma_ack_n |=>
      state_ff == UED_ST_RUN)
      else $error("end notice taken without acknowledge");
   a_nonmux_select: assert property (!mux_bus_ff && wr_rise && !cs_n && dma_ack_n
      && cmd_data_select |=> cmd_valid && cmd_byte == $past(wdata_ff))
      else $error("command write lost on separate bus");

   c_dma_done: cover property (dma_done);
   c_short_end: cover property (pkt_end && rnext < pkt_size);
   c_tx_delivered: cover property (wait_ack_ff && usb_tx_ack);
   c_burst_gap: cover property (burst_mode && burst_end ##[1:20] dma_request_out);

endmodule : ued_dma_port

// [hw/ued_dma_port_end.sv]
// ued_dma_port_end: holds no logic; the port's modules sit in the other hw files

// [hw/ued_ep_map.sv]
// ued_ep_map: endpoint buffer sizes for the configured endpoint mode
`timescale 1ns/1ps
module ued_ep_map
   import ued_pkg::*;
(
   // configuration
   input ued_mode_t ep_mode,
   input wire logic [2:0] sel_index,
   // sizes, zero where the index does not exist in this mode
   output logic [7:0] sel_size,
   output logic [7:0] main_out_size,
   output logic [7:0] main_in_size
);
   always_comb begin
      sel_size = ued_ep_size(ep_mode, sel_index);
      main_out_size = ued_ep_size(ep_mode, UED_IDX_MAIN_OUT);
      main_in_size = ued_ep_size(ep_mode, UED_IDX_MAIN_IN);
   end

endmodule : ued_ep_map

// [hw/ued_fifo.sv]
// ued_fifo: flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module ued_fifo
   import ued_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = UED_FIFO_DEPTH
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] rptr_ff;
   logic [AW:0] cnt_ff;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] ptr);
      return (ptr == AW'(DEPTH - 1)) ? '0 : AW'(ptr + 1'b1);
   endfunction : wrap_inc

   assign in_ready = (cnt_ff != (AW + 1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rptr_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) mem_ff[wptr_ff] <= in_data;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wptr_ff <= wrap_inc(wptr_ff);
         if (pop) rptr_ff <= wrap_inc(rptr_ff);
         if (push & ~pop) cnt_ff <= cnt_ff + 1'b1;
         else if (pop & ~push) cnt_ff <= cnt_ff - 1'b1;
      end
   end

endmodule : ued_fifo

// [hw/ued_pkg.sv]
// ued_pkg: shared constants, types and endpoint sizing for the endpoint dma port
package ued_pkg;

   // ----------------------------------------------------------------
   // sizes and depths
   // ----------------------------------------------------------------
   localparam int UED_FIFO_DEPTH = 16;
   localparam int UED_BUF_BYTES = 128;
   localparam logic [7:0] UED_SIZE_SMALL = 8'h10;
   localparam logic [7:0] UED_SIZE_MAIN = 8'h40;
   localparam logic [7:0] UED_SIZE_MAIN_ISO = 8'h80;
   localparam logic [7:0] UED_SIZE_NONE = 8'h00;

   // ----------------------------------------------------------------
   // endpoint indices and select command codes
   // ----------------------------------------------------------------
   localparam logic [2:0] UED_IDX_MAIN_OUT = 3'h4;
   localparam logic [2:0] UED_IDX_MAIN_IN = 3'h5;
   localparam logic [7:0] UED_SEL_CODE_LAST = 8'h05;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [2:0] UED_SEL_EP_RST = 3'h0;
   localparam logic UED_A0_RST = 1'b1;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      UED_MODE_NONISO = 2'h0,
      UED_MODE_ISO_OUT = 2'h1,
      UED_MODE_ISO_IN = 2'h2,
      UED_MODE_ISO_IO = 2'h3
   } ued_mode_t;

   typedef enum logic [1:0] {
      UED_ST_IDLE = 2'h0,
      UED_ST_RUN = 2'h1,
      UED_ST_DONE = 2'h3
   } ued_state_t;

   typedef struct packed {
      logic last;
      logic [7:0] data;
   } ued_byte_t;

   // buffer size of one endpoint index in a given mode, zero when absent
   function automatic logic [7:0] ued_ep_size(input ued_mode_t mode, input logic [2:0] idx);
      logic [7:0] size;
      size = UED_SIZE_NONE;
      if (idx < UED_IDX_MAIN_OUT) begin
         size = UED_SIZE_SMALL;
      end else if (idx == UED_IDX_MAIN_OUT) begin
         if (mode == UED_MODE_ISO_OUT) size = UED_SIZE_MAIN_ISO;
         else if (mode != UED_MODE_ISO_IN) size = UED_SIZE_MAIN;
      end else if (idx == UED_IDX_MAIN_IN) begin
         if (mode == UED_MODE_ISO_IN) size = UED_SIZE_MAIN_ISO;
         else if (mode != UED_MODE_ISO_OUT) size = UED_SIZE_MAIN;
      end
      return size;
   endfunction : ued_ep_size

endpackage : ued_pkg

// [tb/tb.sv]
// tb: endpoint map, command and dma read tests for the endpoint dma port
`timescale 1ns/1ps
module tb;
   import ued_pkg::*;
   logic ref_clk, rst_n, cs_n, wr_n, sel, go, bmode, rx_valid, stop, tb_end_n, to_host;
   logic req, ack_n, rd_n, end_n, done, cmd_valid, rx_ready, oe, act, ep_wr;
   logic [7:0] din, data_out, cmd_byte, ep_max_size, exp, blen, ep_wdata;
   logic [2:0] epi;
   ued_mode_t mode;
   ued_byte_t rx;
   int num_errors = 0, total_checks = 0, ncmd = 0, ndone = 0, nep = 0, cnt, sum, c0, s0;

   ued_dma_port ued_dma_port_i (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .ale(1'b0), .cmd_data_select(sel), .data_in(din), .data_out(data_out),
      .data_oe(oe), .dma_request_out(req), .dma_ack_n(ack_n), .transfer_end_n(end_n & tb_end_n),
      .dma_go(go), .burst_mode(bmode), .burst_len(blen), .dma_to_host(to_host),
      .ep_mode(mode), .dma_active(act), .dma_done(done), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .ep_wr(ep_wr), .ep_rd(), .ep_index(epi), .ep_wdata(ep_wdata),
      .ep_max_size(ep_max_size), .ep_rdata(8'h00), .usb_rx_valid(rx_valid), .usb_rx(rx),
      .usb_rx_ready(rx_ready), .usb_in_token(1'b0), .usb_tx_valid(), .usb_tx(),
      .usb_tx_ready(1'b0), .usb_tx_ack(1'b0));
   ued_external_transfer_controller_model ued_external_transfer_controller_model_i (.ref_clk(ref_clk), .stop(stop), .dma_request_out(req),
      .data_out(data_out), .dma_ack_n(ack_n), .rd_n(rd_n), .transfer_end_n(end_n),
      .count(cnt), .sum(sum));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
      total_checks++;
      if (seen !== expv) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, expv, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   task automatic cmd_write(input logic a0, input logic [7:0] b);
      @(negedge ref_clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      sel = a0;
      din = b;
      @(negedge ref_clk);
      wr_n = 1'b1;
      @(negedge ref_clk);
      cs_n = 1'b1;
   endtask : cmd_write
   task automatic send_pkt(input int n);
      for (int i = 0; i < n; i++) begin
         rx_valid = 1'b1;
         rx = '{last: (i == n - 1), data: i[7:0]};
         // ready only moves on rising edges, so its falling-edge value is what gets sampled
         while (rx_ready !== 1'b1) @(negedge ref_clk);
         @(negedge ref_clk);
      end
      rx_valid = 1'b0;
   endtask : send_pkt

   // ----------------------------------------------------------------
   // monitors and watchdog
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (cmd_valid === 1'b1) ncmd <= ncmd + 1;
      if (done === 1'b1) ndone <= ndone + 1;
      if (ep_wr === 1'b1) nep <= nep + 1;
   end
   always @(negedge ref_clk) begin
      #1;
      if (go && !bmode && ack_n === 1'b0 && rd_n === 1'b1) check("req_single", req, 1'b0);
      if (ack_n === 1'b0 && rd_n === 1'b1) check("data_oe", oe, 1'b1);
   end
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_n, go, bmode, rx_valid, stop, to_host, din} = '0;
      {cs_n, wr_n, sel, tb_end_n} = '1;
      mode = UED_MODE_NONISO;
      rx = '0;
      blen = 8'h04;
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      check("req_reset", req, 1'b0);
      for (int m = 0; m < 4; m++) begin
         mode = ued_mode_t'(m);
         for (int i = 0; i < 6; i++) begin
            cmd_write(1'b1, 8'(i));
            repeat (3) @(negedge ref_clk);
            exp = (i < 4) ? 8'h10 : (m == 0 || m == 3) ? 8'h40 :
               ((i == 4) == (m == 1)) ? 8'h80 : 8'h00;
            check("ep_max_size", ep_max_size, exp);
         end
      end
      check("cmd_count", ncmd, 24);
      check("cmd_byte", cmd_byte, 8'h05);
      // data phase to a small endpoint, which also leaves the main endpoint unselected
      cmd_write(1'b1, 8'h02);
      cmd_write(1'b0, 8'hA5);
      repeat (2) @(negedge ref_clk);
      check("ep_index", epi, 3'h2);
      check("ep_wdata", ep_wdata, 8'hA5);
      check("ep_wr", nep, 1);
      go = 1'b1;
      tb_end_n = 1'b0;
      repeat (5) @(negedge ref_clk);
      tb_end_n = 1'b1;
      check("req_empty", req, 1'b0);
      check("done_noack", ndone, 0);
      check("dma_active", act, 1'b1);
      for (int b = 0; b < 2; b++) begin
         bmode = b[0];
         go = 1'b1;
         c0 = cnt;
         s0 = sum;
         send_pkt(64);
         send_pkt(10);
         for (int i = 0; i < 3000 && cnt < c0 + 74; i++) @(negedge ref_clk);
         check("xfer_count", cnt - c0, 74);
         check("xfer_sum", sum - s0, 2061);
         stop = 1'b1;
         send_pkt(1);
         for (int i = 0; i < 300 && ndone < b + 1; i++) @(negedge ref_clk);
         stop = 1'b0;
         check("dma_done", ndone, b + 1);
         go = 1'b0;
         repeat (4) @(negedge ref_clk);
         check("req_idle", req, 1'b0);
         check("idle_active", act, 1'b0);
      end
      end_of_test();
   end
endmodule : tb

// [tb/ued_external_transfer_controller_model.sv]
// ued_external_transfer_controller_model: demand-mode single-address dma controller draining the main endpoint
`timescale 1ns/1ps
module ued_external_transfer_controller_model (
   // clock and control
   input wire logic ref_clk,
   input wire logic stop,
   // handshake and data
   input wire logic dma_request_out,
   input wire logic [7:0] data_out,
   output logic dma_ack_n,
   output logic rd_n,
   output logic transfer_end_n,
   // statistics
   output int count,
   output int sum
);
   initial begin
      dma_ack_n = 1'b1;
      rd_n = 1'b1;
      transfer_end_n = 1'b1;
      count = 0;
      sum = 0;
      forever begin
         @(negedge ref_clk);
         // moves a byte only while asked to
         if (dma_request_out === 1'b1) begin
            dma_ack_n = 1'b0;
            rd_n = 1'b0;
            transfer_end_n = !stop;
            @(negedge ref_clk);
            sum = sum + data_out;
            count = count + 1;
            rd_n = 1'b1;
            transfer_end_n = 1'b1;
            // ack held past the strobe's rising edge
            @(negedge ref_clk);
            dma_ack_n = 1'b1;
         end
      end
   end
endmodule : ued_external_transfer_controller_model
